// >>> logic/erh_ram.sv
/*
  ECC RAM wrapper with the corrected-error spurious-write defect.
  Assumes masters on sys_clk hold a request until req_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module erh_ram #(
  parameter int         ADDR_W   = 6,
  parameter logic [1:0] MEM_KIND = erh_pkg::KIND_MAILBOX
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          ecc_en,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic [1:0]                    req_cmd,
  input  wire logic [ADDR_W-1:0]             req_addr,
  input  wire logic [erh_pkg::DATA_W-1:0]    req_wdata,
  input  wire logic [erh_pkg::DATA_W/8-1:0]  req_be,
  input  wire logic [erh_pkg::DATA_W-1:0]    inj_flip,
  output logic                               rsp_valid,
  output logic      [erh_pkg::DATA_W-1:0]    rsp_rdata,
  output logic                               rsp_sec,
  output logic                               rsp_ded,
  output logic                               err_sec,
  output logic                               err_ded,
  output logic                               spur_wr,
  output logic      [ADDR_W-1:0]             spur_addr,
  output logic      [erh_pkg::CNT_W-1:0]     sec_count
);
  localparam int DW = erh_pkg::DATA_W;
  localparam int CW = erh_pkg::CHK_W;
  localparam int WW = DW + CW;
  localparam bit HAZ_ON = (MEM_KIND == erh_pkg::KIND_MAILBOX) ||
                          (MEM_KIND == erh_pkg::KIND_LEVEL_TWO);

  // No reset on storage; contents are undefined until written
  logic [WW-1:0] mem_q [2**ADDR_W];

  erh_pkg::erh_state_e state_q, state_d;
  logic                hz_q, hz_d;
  logic                hz_pw_q, hz_pw_d;
  logic                hz_wr_q, hz_wr_d;
  logic [DW-1:0]       hz_data_q, hz_data_d;
  logic [DW-1:0]       spur_data_q;
  logic [ADDR_W-1:0]   spur_addr_q;
  logic [ADDR_W-1:0]   last_wr_q;
  logic [erh_pkg::CNT_W-1:0] cnt_q;
  logic                rsp_valid_q, rsp_sec_q, rsp_ded_q, err_sec_q, err_ded_q;
  logic [DW-1:0]       rsp_rdata_q;

  // ----------------------------------------
  // Decode and array read
  // ----------------------------------------
  wire           accept   = req_valid && req_ready;
  wire           is_rd    = req_cmd == erh_pkg::CMD_READ;
  wire           is_fw    = req_cmd == erh_pkg::CMD_FULL;
  wire           is_pw    = req_cmd == erh_pkg::CMD_PART;
  wire           in_spur  = state_q == erh_pkg::ERH_SPUR;
  wire [WW-1:0]  rd_word  = mem_q[req_addr];
  wire [DW-1:0]  cor_data;
  wire           sec_raw;
  wire           ded_raw;
  wire [CW-1:0]  enc_chk;
  wire           arr_rd   = accept && (is_rd || is_pw);
  wire           sec_hit  = arr_rd && ecc_en && sec_raw;
  wire           ded_hit  = arr_rd && ecc_en && ded_raw;
  wire [DW-1:0]  use_data = ecc_en ? cor_data : rd_word[DW-1:0];
  wire [DW-1:0]  merged;
  wire           armed    = HAZ_ON && hz_q;
  wire           trig     = accept && is_pw && armed && (hz_pw_q || hz_wr_q);
  wire           consume  = arr_rd && armed;
  wire           do_wr    = (accept && (is_fw || is_pw)) || in_spur;
  wire [DW-1:0]  wr_clean = in_spur ? spur_data_q : (is_pw ? merged : req_wdata);
  wire [DW-1:0]  wr_flip  = in_spur ? '0 : inj_flip;
  wire [ADDR_W-1:0] wr_addr = in_spur ? spur_addr_q : req_addr;

  genvar b;
  generate
    for (b = 0; b < DW / 8; b++) begin : g_merge
      assign merged[b*8 +: 8] = req_be[b] ? req_wdata[b*8 +: 8] : use_data[b*8 +: 8];
    end
  endgenerate

  erh_secded u_codec (
    .enc_data (wr_clean),
    .enc_chk  (enc_chk),
    .dec_data (rd_word[DW-1:0]),
    .dec_chk  (rd_word[WW-1:DW]),
    .cor_data (cor_data),
    .sec      (sec_raw),
    .ded      (ded_raw)
  );

  // ----------------------------------------
  // Hazard tracking
  // ----------------------------------------
  assign req_ready = !in_spur;
  assign state_d   = trig ? erh_pkg::ERH_SPUR : erh_pkg::ERH_IDLE;
  // corrected error arms, set beats clear
  assign hz_d      = (HAZ_ON && sec_hit) || (hz_q && !consume);
  assign hz_pw_d   = sec_hit ? is_pw : hz_pw_q;
  // full writes keep the hazard alive
  assign hz_wr_d   = sec_hit ? 1'b0 : (hz_wr_q || (accept && is_fw && hz_q));
  assign hz_data_d = sec_hit ? use_data : hz_data_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= erh_pkg::ERH_IDLE;
      hz_q    <= 1'b0;
      hz_pw_q <= 1'b0;
      hz_wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hz_q    <= hz_d;
      hz_pw_q <= hz_pw_d;
      hz_wr_q <= hz_wr_d;
    end
  end

  // stale corrected data to last address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hz_data_q   <= '0;
      spur_data_q <= '0;
      spur_addr_q <= '0;
      last_wr_q   <= '0;
    end else begin
      hz_data_q <= hz_data_d;
      if (trig) begin
        spur_data_q <= hz_data_q;
        spur_addr_q <= last_wr_q;
      end
      if (do_wr) last_wr_q <= wr_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_wr) mem_q[wr_addr] <= {enc_chk, wr_clean ^ wr_flip};
  end

  // ----------------------------------------
  // Responses and counter
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      rsp_sec_q   <= 1'b0;
      rsp_ded_q   <= 1'b0;
      err_sec_q   <= 1'b0;
      err_ded_q   <= 1'b0;
      cnt_q       <= erh_pkg::SEC_CNT_RST;
    end else begin
      rsp_valid_q <= accept && is_rd;
      if (accept && is_rd) rsp_rdata_q <= use_data;
      rsp_sec_q   <= sec_hit && is_rd;
      rsp_ded_q   <= ded_hit && is_rd;
      err_sec_q   <= sec_hit;
      err_ded_q   <= ded_hit;
      if (sec_hit && cnt_q != erh_pkg::SEC_CNT_MAX) cnt_q <= cnt_q + 1'b1;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_sec   = rsp_sec_q;
  assign rsp_ded   = rsp_ded_q;
  assign err_sec   = err_sec_q;
  assign err_ded   = err_ded_q;
  assign spur_wr   = in_spur;
  assign spur_addr = spur_addr_q;
  assign sec_count = cnt_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  spur_one_shot_a: assert property (trig |=> spur_wr ##1 !spur_wr)
    else $error("spurious write not exactly one cycle");
  spur_cause_a: assert property ($rose(spur_wr) |-> $past(trig))
    else $error("spurious write without trigger");
  read_clears_a: assert property (consume && is_rd && !sec_hit |=> !hz_q)
    else $error("host read did not clear hazard");
  arm_on_sec_a: assert property (HAZ_ON && sec_hit |=> hz_q)
    else $error("corrected error did not arm hazard");
  spur_target_a: assert property (trig |=> spur_addr == $past(last_wr_q))
    else $error("spurious write aimed at wrong address");
  spur_data_a: assert property (trig |=> spur_data_q == $past(hz_data_q))
    else $error("spurious write carries wrong data");
  read_then_pw_a: assert property (hz_q && !hz_pw_q && !hz_wr_q && accept && is_pw |=> !spur_wr)
    else $error("read error followed by partial write rewrote memory");
  other_kind_a: assert property (!HAZ_ON |-> !hz_q && !spur_wr)
    else $error("hazard in unaffected memory");
  ecc_off_a: assert property (!ecc_en && arr_rd |=> !err_sec && !err_ded)
    else $error("error flagged with correction off");
  count_still_a: assert property (spur_wr |=> $stable(sec_count))
    else $error("counter moved on spurious write");
  // Double errors are flagged, never corrected
  ded_flag_a: assert property (ded_hit |=> err_ded && !err_sec)
    else $error("double error not flagged alone");
  // Saturating, so a full count hides later corrections
  sec_count_a: assert property (sec_hit && sec_count != erh_pkg::SEC_CNT_MAX |=>
    sec_count == $past(sec_count) + 8'h01)
    else $error("corrected error not counted");

  // Main scenarios
  cov_spur_c:   cover property (trig ##1 spur_wr);
  cov_clear_c:  cover property (hz_q && consume && is_rd ##1 !hz_q);
  cov_full_c:   cover property (hz_wr_q && trig);
  cov_pw_arm_c: cover property (sec_hit && is_pw);
  cov_ded_c:    cover property (ded_hit);
endmodule
`default_nettype wire

// >>> logic/erh_pkg.sv
/*
  Constants and helpers for the ECC RAM wrapper that carries the
  spurious-write hazard after a corrected single-bit error.
  Assumes one clock domain and masters on the same clock.
*/
package erh_pkg;

  localparam int DATA_W = 32;
  localparam int SYN_W  = 6;
  localparam int CHK_W  = SYN_W + 1;
  localparam int CNT_W  = 8;

  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_FULL = 2'h1;
  localparam logic [1:0] CMD_PART = 2'h2;

  localparam logic [1:0] KIND_OTHER     = 2'h0;
  localparam logic [1:0] KIND_MAILBOX   = 2'h1;
  localparam logic [1:0] KIND_LEVEL_TWO = 2'h2;

  localparam logic [CNT_W-1:0] SEC_CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] SEC_CNT_MAX = 8'hFF;

  typedef enum logic {ERH_IDLE, ERH_SPUR} erh_state_e;

  // Hamming position of data bit i, skipping powers of two
  function automatic logic [SYN_W-1:0] erh_pos(input int i);
    int n;
    logic [SYN_W-1:0] r;
    n = -1;
    r = '0;
    for (int p = 3; p < 64; p++) begin
      if ((p & (p - 1)) != 0) begin
        n++;
        if (n == i) r = p[SYN_W-1:0];
      end
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] erh_mask(input int j);
    logic [DATA_W-1:0] m;
    logic [SYN_W-1:0]  p;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      p    = erh_pos(i);
      m[i] = p[j];
    end
    return m;
  endfunction

endpackage

// >>> logic/erh_secded.sv
/*
  SECDED encoder and decoder, purely combinational.
  Assumes the caller registers whatever it needs.
*/
`timescale 1ns/1ps
`default_nettype none
module erh_secded (
  input  wire logic [erh_pkg::DATA_W-1:0] enc_data,
  output logic      [erh_pkg::CHK_W-1:0]  enc_chk,
  input  wire logic [erh_pkg::DATA_W-1:0] dec_data,
  input  wire logic [erh_pkg::CHK_W-1:0]  dec_chk,
  output logic      [erh_pkg::DATA_W-1:0] cor_data,
  output logic                            sec,
  output logic                            ded
);
  localparam int SW = erh_pkg::SYN_W;
  logic [SW-1:0]              syn;
  logic [erh_pkg::DATA_W-1:0] flip;
  logic                       par_bad;

  // ----------------------------------------
  // Check bits and syndrome
  // ----------------------------------------
  genvar j, i;
  generate
    for (j = 0; j < SW; j++) begin : g_chk
      assign enc_chk[j] = ^(enc_data & erh_pkg::erh_mask(j));
      assign syn[j]     = (^(dec_data & erh_pkg::erh_mask(j))) ^ dec_chk[j];
    end
    for (i = 0; i < erh_pkg::DATA_W; i++) begin : g_fix
      assign flip[i] = par_bad && (syn == erh_pkg::erh_pos(i));
    end
  endgenerate

  assign enc_chk[SW] = ^{enc_data, enc_chk[SW-1:0]};
  assign par_bad     = ^{dec_data, dec_chk};
  assign cor_data    = dec_data ^ flip;
  assign sec         = par_bad;
  assign ded         = !par_bad && (syn != '0);
endmodule
`default_nettype wire

// >>> sim/erh_master.sv
/*
  Bus master model for the wrapper's host port.
  Assumes req_ready is settled well before each falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module erh_master (
  input  wire logic        sys_clk,
  input  wire logic        req_ready,
  output logic             req_valid,
  output logic [1:0]       req_cmd,
  output logic [5:0]       req_addr,
  output logic [31:0]      req_wdata,
  output logic [3:0]       req_be,
  output logic [31:0]      inj_flip
);
  // ---------------------------------
  // Request driver
  // ---------------------------------
  initial begin
    req_valid = 1'b0;
    req_cmd   = 2'h0;
    req_addr  = 6'h00;
    req_wdata = 32'h0;
    req_be    = 4'h0;
    inj_flip  = 32'h0;
  end

  // Called at a rising edge; holds all fields until ready seen at an edge
  task automatic issue(input logic [1:0] c, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] b, input logic [31:0] f);
    logic rdy;
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_addr  <= a;
    req_wdata <= d;
    req_be    <= b;
    inj_flip  <= f;
    do begin
      @(negedge sys_clk);
      rdy = req_ready;
      @(posedge sys_clk);
    end while (!rdy);
  endtask

  // Released data toggles so stale values are never mistaken for valid ones
  task automatic idle();
    req_valid <= 1'b0;
    req_wdata <= ~req_wdata;
    inj_flip  <= 32'h0;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> sim/erh_ram_test.sv
/*
  Self-checking bench for the ECC RAM wrapper hazard model.
  Assumes a mailbox-kind instance and a master model on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module erh_ram_test;
  logic        sys_clk;
  logic        rst;
  logic        ecc_en;
  logic        req_valid;
  logic        req_ready;
  logic [1:0]  req_cmd;
  logic [5:0]  req_addr;
  logic [31:0] req_wdata;
  logic [3:0]  req_be;
  logic [31:0] inj_flip;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        rsp_sec;
  logic        rsp_ded;
  logic        spur_wr;
  logic [5:0]  spur_addr;
  logic [7:0]  sec_count;
  logic        err_sec;
  logic        err_ded;
  logic        oth_spur;
  logic [31:0] rd_q;
  logic        sec_q;
  logic        ded_q;
  int          spur_n;
  int          rsp_n;
  int          esec_n;
  int          eded_n;
  int          stall_n;
  int          oth_n;
  int          bad_count;
  int          total_checks;

  erh_ram u_erh_ram (.sys_clk(sys_clk), .rst(rst), .ecc_en(ecc_en), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_be(req_be), .inj_flip(inj_flip), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_sec(rsp_sec), .rsp_ded(rsp_ded), .err_sec(err_sec), .err_ded(err_ded), .spur_wr(spur_wr),
    .spur_addr(spur_addr), .sec_count(sec_count));
  erh_master u_erh_master (.sys_clk(sys_clk), .req_ready(req_ready), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .inj_flip(inj_flip));
  // Unaffected memory kind sees the same traffic and must never misbehave
  erh_ram #(.MEM_KIND(erh_pkg::KIND_OTHER)) u_erh_ram_other (.sys_clk(sys_clk), .rst(rst),
    .ecc_en(ecc_en), .req_valid(req_valid), .req_ready(), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .inj_flip(inj_flip), .rsp_valid(), .rsp_rdata(),
    .rsp_sec(), .rsp_ded(), .err_sec(), .err_ded(), .spur_wr(oth_spur), .spur_addr(),
    .sec_count());

  // ---------------------------------
  // Clock, monitor and helpers
  // ---------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    spur_n  = 0;
    rsp_n   = 0;
    esec_n  = 0;
    eded_n  = 0;
    stall_n = 0;
    oth_n   = 0;
  end
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      rd_q  <= rsp_rdata;
      sec_q <= rsp_sec;
      ded_q <= rsp_ded;
      rsp_n <= rsp_n + 1;
    end
    if (spur_wr === 1'b1) spur_n <= spur_n + 1;
    if (err_sec === 1'b1) esec_n <= esec_n + 1;
    if (err_ded === 1'b1) eded_n <= eded_n + 1;
    if (req_ready === 1'b0) stall_n <= stall_n + 1;
    if (oth_spur === 1'b1) oth_n <= oth_n + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [31:0] f);
    u_erh_master.issue(erh_pkg::CMD_FULL, a, d, 4'hF, f);
  endtask

  task automatic pw(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    u_erh_master.issue(erh_pkg::CMD_PART, a, d, b, 32'h0);
  endtask

  // Read, let the response land, then judge data and flags
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input logic s, input logic dd);
    int r0;
    r0 = rsp_n;
    u_erh_master.issue(erh_pkg::CMD_READ, a, 32'h0, 4'h0, 32'h0);
    u_erh_master.idle();
    chk("rdata", e, rd_q);
    chk("sec", {31'h0, s}, {31'h0, sec_q});
    chk("ded", {31'h0, dd}, {31'h0, ded_q});
    chk("rsp count", 32'd1, rsp_n - r0);
  endtask

  task automatic settle();
    u_erh_master.idle();
    u_erh_master.idle();
  endtask

  // ---------------------------------
  // Scenarios
  // ---------------------------------
  task automatic t_part_then_part();
    int n0;
    int s0;
    int e0;
    n0 = spur_n;
    s0 = stall_n;
    e0 = esec_n;
    wr(6'h05, 32'hCAFE_0001, 32'h0000_0008);
    wr(6'h06, 32'h1111_2222, 32'h0);
    pw(6'h05, 32'hAAAA_AAAA, 4'h1);
    pw(6'h06, 32'hABCD_EF01, 4'h2);
    settle();
    chk("spur count", 32'd1, spur_n - n0);
    chk("spur addr", 32'h05, {26'h0, spur_addr});
    rd_chk(6'h05, 32'hCAFE_0001, 1'b0, 1'b0);
    rd_chk(6'h06, 32'h1111_EF22, 1'b0, 1'b0);
    chk("sec count", 32'h1, {24'h0, sec_count});
    chk("stall count", 32'd1, stall_n - s0);
    chk("err sec", 32'd1, esec_n - e0);
    chk("other spur", 32'd0, oth_n);
    $display("test part_then_part done");
  endtask

  task automatic t_read_full_part();
    int n0;
    int s0;
    wr(6'h0B, 32'h0, 32'h0);
    wr(6'h08, 32'h2468_ACE0, 32'h4000_0000);
    n0 = spur_n;
    s0 = stall_n;
    rd_chk(6'h08, 32'h2468_ACE0, 1'b1, 1'b0);
    wr(6'h09, 32'h9999_9999, 32'h0);
    wr(6'h0A, 32'hAAAA_0000, 32'h0);
    pw(6'h0B, 32'h1234_5678, 4'h4);
    settle();
    chk("spur count", 32'd1, spur_n - n0);
    chk("spur addr", 32'h0A, {26'h0, spur_addr});
    rd_chk(6'h0A, 32'h2468_ACE0, 1'b0, 1'b0);
    chk("stall count", 32'd1, stall_n - s0);
    $display("test read_full_part done");
  endtask

  task automatic t_read_clears();
    int n0;
    int e0;
    wr(6'h0C, 32'h4444_0000, 32'h0000_0001);
    wr(6'h0D, 32'h5555_6666, 32'h0);
    n0 = spur_n;
    e0 = esec_n;
    rd_chk(6'h0C, 32'h4444_0000, 1'b1, 1'b0);
    rd_chk(6'h0D, 32'h5555_6666, 1'b0, 1'b0);
    pw(6'h0D, 32'h0F0F_0F0F, 4'h8);
    settle();
    rd_chk(6'h0C, 32'h4444_0000, 1'b1, 1'b0);
    pw(6'h0D, 32'h7777_7777, 4'h1);
    settle();
    chk("spur count", 32'd0, spur_n - n0);
    rd_chk(6'h0C, 32'h4444_0000, 1'b1, 1'b0);
    rd_chk(6'h0D, 32'h0F55_6677, 1'b0, 1'b0);
    wr(6'h0E, 32'h1357_9BDF, 32'h0000_0300);
    rd_chk(6'h0E, 32'h1357_9BDF ^ 32'h0000_0300, 1'b0, 1'b1);
    chk("sec count", 32'h5, {24'h0, sec_count});
    chk("err sec", 32'd3, esec_n - e0);
    chk("err ded", 32'd1, eded_n);
    $display("test read_clears done");
  endtask

  // Software avoidances: correction off, full writes only, scrub on error
  task automatic t_avoid();
    int n0;
    n0 = spur_n;
    ecc_en <= 1'b0;
    wr(6'h10, 32'h0000_00F0, 32'h0000_0010);
    pw(6'h10, 32'h1100_0000, 4'h8);
    pw(6'h10, 32'h0000_2200, 4'h2);
    wr(6'h11, 32'hA5A5_A5A5, 32'h0000_0001);
    rd_chk(6'h11, 32'hA5A5_A5A4, 1'b0, 1'b0);
    rd_chk(6'h10, 32'h1100_22E0, 1'b0, 1'b0);
    chk("sec count", 32'h5, {24'h0, sec_count});
    ecc_en <= 1'b1;
    rd_chk(6'h11, 32'hA5A5_A5A5, 1'b1, 1'b0);
    wr(6'h12, 32'h3C3C_5A5A, 32'h0);
    wr(6'h11, 32'hA5A5_A5A5, 32'h0);
    rd_chk(6'h11, 32'hA5A5_A5A5, 1'b0, 1'b0);
    rd_chk(6'h12, 32'h3C3C_5A5A, 1'b0, 1'b0);
    settle();
    chk("spur count", 32'd0, spur_n - n0);
    chk("sec count", 32'h6, {24'h0, sec_count});
    $display("test avoid done");
  endtask

  // ---------------------------------
  // Sequence and verdict
  // ---------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    total_checks = 0;
    rst = 1'b1;
    ecc_en = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_part_then_part();
    t_read_full_part();
    t_read_clears();
    t_avoid();
    summarize();
  end

  // Whole run is under a hundred cycles; this bound is generous
  initial begin
    #50us;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
